// ### osc_ctrl_params.svh
`ifndef OSC_CTRL_PARAMS_SVH
`define OSC_CTRL_PARAMS_SVH
// ==========================================================
// Register offsets
`define ADDR_OSC_CONTROL 12'h000
`define ADDR_CLOCK_DIVIDER 12'h004
`define ADDR_FAST_RC_TUNE 12'h008
`define ADDR_UNLOCK_HI 12'h00c
`define ADDR_UNLOCK_LO 12'h010
`define ADDR_IRQ_STATUS 12'h014
`define ADDR_IRQ_MASK 12'h018
// ==========================================================
// Unlock keys
`define KEY_HI_1 8'h78
`define KEY_HI_2 8'h9a
`define KEY_LO_1 8'h46
`define KEY_LO_2 8'h57
// ==========================================================
// Field positions
`define POS_CUR 12
`define POS_NXT 8
`define POS_SEL_LOCK 7
`define POS_PIN_LOCK 6
`define POS_PLL_LOCK 5
`define POS_FAIL 3
`define POS_SECONDARY_OSC 1
`define POS_SWREQ 0
`define POS_ROI 15
`define POS_RATIO 12
`define POS_SLOW_EN 11
`define POS_POST 8
// ==========================================================
// Reset values and timing
`define RST_POST 3'h1
`define RST_TRIM 6'h00
`define RST_RATIO 3'h0
`define SETTLE_CYCLES 4'ha
`endif

// ### osc_ctrl_pkg.sv
package osc_ctrl_pkg;
	typedef enum logic [2:0] {
		SRC_FRC = 3'h0,
		SRC_FRC_PLL = 3'h1,
		SRC_PRI = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC = 3'h4,
		SRC_LOW_POWER_RC_OSC = 3'h5,
		SRC_RSVD = 3'h6,
		SRC_FRC_DIV = 3'h7
	} clk_src_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READY = 4'b0010,
		ST_SETTLE = 4'b0100,
		ST_DONE = 4'b1000
	} sw_state_t;
	typedef struct packed {
		logic sw_enable;
		logic monitor_en;
		logic pin_one_way;
		logic [2:0] init_src;
	} cfg_t;
	typedef struct packed {
		logic clock_fail;
		logic pll_locked;
		logic src_ready;
		logic new_clk_tick;
		logic interrupt;
	} osc_status_t;
	typedef struct packed {
		logic [2:0] active_src;
		logic sec_osc_on;
		logic cpu_slow_on;
		logic [2:0] cpu_slow_ratio;
		logic [2:0] fast_rc_postscale;
		logic [5:0] fast_rc_trim;
		logic switching;
	} osc_ctrl_t;
endpackage

// ### osc_ctrl.sv
`timescale 1ns/1ps
`include "osc_ctrl_params.svh"
module osc_ctrl
	import osc_ctrl_pkg::*;
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration and oscillator status
	input wire cfg_t cfg,
	input wire osc_status_t stat,
	// Control
	output osc_ctrl_t ctrl,
	output logic irq
);
	// ==========================================================
	// Input synchronisers
	osc_status_t st_s1_ff, st_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_s1_ff <= '0;
			st_ff <= '0;
		end else begin
			st_s1_ff <= stat;
			st_ff <= st_s1_ff;
		end
	end
	// ==========================================================
	// Bus decode
	logic acc, wr, rd;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	logic [7:0] wb_hi, wb_lo;
	assign wb_hi = pwdata[15:8];
	assign wb_lo = pwdata[7:0];
	logic wr_osc;
	assign wr_osc = wr && paddr == `ADDR_OSC_CONTROL;
	// ==========================================================
	// Unlock sequencing: key pair at unlock offsets, then one write
	logic [1:0] hi_key_ff, lo_key_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_key_ff <= 2'h0;
			lo_key_ff <= 2'h0;
		end else if (wr) begin
			if (paddr == `ADDR_UNLOCK_HI) begin
				if (wb_hi == `KEY_HI_1)
					hi_key_ff <= 2'h1;
				else if (wb_hi == `KEY_HI_2 && hi_key_ff == 2'h1)
					hi_key_ff <= 2'h2;
				else
					hi_key_ff <= 2'h0;
			end else begin
				hi_key_ff <= 2'h0;
			end
			if (paddr == `ADDR_UNLOCK_LO) begin
				if (wb_lo == `KEY_LO_1)
					lo_key_ff <= 2'h1;
				else if (wb_lo == `KEY_LO_2 && lo_key_ff == 2'h1)
					lo_key_ff <= 2'h2;
				else
					lo_key_ff <= 2'h0;
			end else begin
				lo_key_ff <= 2'h0;
			end
		end
	end
	logic hi_open, lo_open;
	assign hi_open = wr_osc && hi_key_ff == 2'h2;
	assign lo_open = wr_osc && lo_key_ff == 2'h2;
	// ==========================================================
	// Configuration capture after reset release
	logic cfg_taken_ff;
	cfg_t cfg_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_taken_ff <= 1'b0;
			cfg_ff <= '0;
		end else if (!cfg_taken_ff) begin
			cfg_taken_ff <= 1'b1;
			cfg_ff <= cfg;
		end
	end
	// ==========================================================
	// Oscillator control register
	logic [2:0] cur_ff, nxt_ff;
	logic sel_lock_ff, pin_lock_ff, pll_lock_ff, fail_ff, secondary_osc_ff, swreq_ff;
	sw_state_t state_ff;
	logic [3:0] settle_ff;
	logic frozen, sw_start, sw_valid, sw_redundant;
	assign frozen = cfg_ff.monitor_en & sel_lock_ff;
	assign sw_start = lo_open & wb_lo[`POS_SWREQ] & cfg_ff.sw_enable & ~frozen
		& state_ff == ST_IDLE;
	assign sw_redundant = sw_start & nxt_ff == cur_ff;
	assign sw_valid = sw_start & nxt_ff != cur_ff;
	function automatic logic uses_pll(input logic [2:0] s);
		uses_pll = s == SRC_FRC_PLL || s == SRC_PRI_PLL;
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_ff <= 3'h0;
			nxt_ff <= 3'h0;
		end else if (!cfg_taken_ff) begin
			cur_ff <= cfg.init_src;
			nxt_ff <= cfg.init_src;
		end else begin
			if (hi_open && state_ff == ST_IDLE && !frozen)
				nxt_ff <= wb_hi[2:0];
			if (state_ff == ST_DONE)
				cur_ff <= nxt_ff;
		end
	end
	// Switch sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			settle_ff <= 4'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (sw_valid)
						state_ff <= ST_READY;
				end
				ST_READY: begin
					settle_ff <= 4'h0;
					if (uses_pll(nxt_ff) ? st_ff.pll_locked : st_ff.src_ready)
						state_ff <= ST_SETTLE;
				end
				ST_SETTLE: begin
					if (st_ff.new_clk_tick) begin
						if (settle_ff == `SETTLE_CYCLES - 4'h1)
							state_ff <= ST_DONE;
						else
							settle_ff <= settle_ff + 4'h1;
					end
				end
				ST_DONE: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			swreq_ff <= 1'b0;
		else if (!cfg_ff.sw_enable)
			swreq_ff <= 1'b0;
		else if (sw_valid)
			swreq_ff <= 1'b1;
		else if (sw_redundant || state_ff == ST_DONE)
			swreq_ff <= 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_lock_ff <= 1'b0;
			pin_lock_ff <= 1'b0;
			secondary_osc_ff <= 1'b0;
		end else if (lo_open) begin
			if (wb_lo[`POS_SEL_LOCK])
				sel_lock_ff <= 1'b1;
			if (!(cfg_ff.pin_one_way && pin_lock_ff))
				pin_lock_ff <= wb_lo[`POS_PIN_LOCK];
			secondary_osc_ff <= wb_lo[`POS_SECONDARY_OSC];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pll_lock_ff <= 1'b0;
		else if (sw_valid || !uses_pll(cur_ff))
			pll_lock_ff <= 1'b0;
		else
			pll_lock_ff <= st_ff.pll_locked;
	end
	logic fail_rise_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fail_rise_ff <= 1'b0;
		else
			fail_rise_ff <= st_ff.clock_fail;
	end
	logic fail_evt;
	assign fail_evt = st_ff.clock_fail & ~fail_rise_ff & cfg_ff.monitor_en;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fail_ff <= 1'b0;
		else if (fail_evt)
			fail_ff <= 1'b1;
		else if (sw_valid || (lo_open && !wb_lo[`POS_FAIL]))
			fail_ff <= 1'b0;
	end
	// ==========================================================
	// Clock divider and trim
	logic roi_ff, slow_en_ff;
	logic [2:0] ratio_ff, post_ff;
	logic [5:0] trim_ff;
	logic wr_div, wr_tun;
	assign wr_div = wr && paddr == `ADDR_CLOCK_DIVIDER;
	assign wr_tun = wr && paddr == `ADDR_FAST_RC_TUNE;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			roi_ff <= 1'b0;
			slow_en_ff <= 1'b0;
			ratio_ff <= `RST_RATIO;
			post_ff <= `RST_POST;
			trim_ff <= `RST_TRIM;
		end else begin
			if (wr_div) begin
				roi_ff <= pwdata[`POS_ROI];
				ratio_ff <= pwdata[`POS_RATIO+:3];
				post_ff <= pwdata[`POS_POST+:3];
			end
			if (roi_ff && st_ff.interrupt)
				slow_en_ff <= 1'b0;
			else if (wr_div)
				slow_en_ff <= pwdata[`POS_SLOW_EN];
			if (wr_tun)
				trim_ff <= pwdata[5:0];
		end
	end
	// ==========================================================
	// Interrupts: 0 switch done, 1 redundant, 2 clock fail
	logic [2:0] ist_ff, imask_ff, ievt;
	assign ievt = {fail_evt, sw_redundant, state_ff == ST_DONE};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_ff <= 3'h0;
			imask_ff <= 3'h0;
			irq <= 1'b0;
		end else begin
			if (wr && paddr == `ADDR_IRQ_STATUS)
				ist_ff <= (ist_ff & ~pwdata[2:0]) | ievt;
			else
				ist_ff <= ist_ff | ievt;
			if (wr && paddr == `ADDR_IRQ_MASK)
				imask_ff <= pwdata[2:0];
			irq <= |(ist_ff & imask_ff);
		end
	end
	// ==========================================================
	// Read mux and outputs
	logic [15:0] osc_word;
	always_comb begin
		osc_word = 16'h0000;
		osc_word[`POS_CUR+:3] = cur_ff;
		osc_word[`POS_NXT+:3] = nxt_ff;
		osc_word[`POS_SEL_LOCK] = sel_lock_ff;
		osc_word[`POS_PIN_LOCK] = pin_lock_ff;
		osc_word[`POS_PLL_LOCK] = pll_lock_ff;
		osc_word[`POS_FAIL] = fail_ff;
		osc_word[`POS_SECONDARY_OSC] = secondary_osc_ff;
		osc_word[`POS_SWREQ] = swreq_ff;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`ADDR_OSC_CONTROL: prdata <= {16'h0, osc_word};
					`ADDR_CLOCK_DIVIDER: prdata <= {16'h0, roi_ff, ratio_ff,
						slow_en_ff, post_ff, 8'h00};
					`ADDR_FAST_RC_TUNE: prdata <= {26'h0, trim_ff};
					`ADDR_IRQ_STATUS: prdata <= {29'h0, ist_ff};
					`ADDR_IRQ_MASK: prdata <= {29'h0, imask_ff};
					`ADDR_UNLOCK_HI, `ADDR_UNLOCK_LO: prdata <= 32'h0;
					default: pslverr <= 1'b1;
				endcase
			end else if (psel && !penable) begin
				case (paddr)
					`ADDR_OSC_CONTROL, `ADDR_CLOCK_DIVIDER, `ADDR_FAST_RC_TUNE,
					`ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_UNLOCK_HI,
					`ADDR_UNLOCK_LO: pslverr <= 1'b0;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= '0;
		else begin
			ctrl.active_src <= cur_ff;
			ctrl.sec_osc_on <= secondary_osc_ff;
			ctrl.cpu_slow_on <= slow_en_ff;
			ctrl.cpu_slow_ratio <= ratio_ff;
			ctrl.fast_rc_postscale <= post_ff;
			ctrl.fast_rc_trim <= trim_ff;
			ctrl.switching <= state_ff != ST_IDLE;
		end
	end
	// ==========================================================
	// Checks
	logic unused_rd;
	assign unused_rd = rd;
	property p_sel_lock_sticky;
		@(posedge pclk) disable iff (!presetn)
		sel_lock_ff |=> sel_lock_ff;
	endproperty
	a_sel_lock_sticky: assert property (p_sel_lock_sticky) else $error("lock cleared");
	property p_redundant;
		@(posedge pclk) disable iff (!presetn)
		sw_redundant |=> !swreq_ff && state_ff == ST_IDLE;
	endproperty
	a_redundant: assert property (p_redundant) else $error("redundant not aborted");
	property p_no_sw;
		@(posedge pclk) disable iff (!presetn)
		cfg_taken_ff && !cfg_ff.sw_enable |=> !swreq_ff;
	endproperty
	a_no_sw: assert property (p_no_sw) else $error("request while disabled");
	property p_pll_clr;
		@(posedge pclk) disable iff (!presetn)
		sw_valid |=> !pll_lock_ff && !fail_ff;
	endproperty
	a_pll_clr: assert property (p_pll_clr) else $error("lock not cleared");
	property p_commit;
		@(posedge pclk) disable iff (!presetn)
		state_ff == ST_DONE |=> cur_ff == $past(nxt_ff) && !swreq_ff;
	endproperty
	a_commit: assert property (p_commit) else $error("switch not committed");
	property p_fail_set;
		@(posedge pclk) disable iff (!presetn)
		fail_evt |=> fail_ff;
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("fail lost");
	property p_roi;
		@(posedge pclk) disable iff (!presetn)
		roi_ff && st_ff.interrupt |=> !slow_en_ff;
	endproperty
	a_roi: assert property (p_roi) else $error("slow enable kept");
	property p_pin_one_way;
		@(posedge pclk) disable iff (!presetn)
		cfg_ff.pin_one_way && pin_lock_ff |=> pin_lock_ff;
	endproperty
	a_pin_one_way: assert property (p_pin_one_way) else $error("pin lock cleared");
endmodule

// ### osc_ctrl_test.sv
`timescale 1ns/1ps
module osc_ctrl_test;
	import osc_ctrl_pkg::*;
	// ==========================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic irq;
	logic er;
	cfg_t cfg = '{1'b1, 1'b1, 1'b1, 3'h7};
	osc_status_t stat = '0;
	osc_ctrl_t ctrl;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} row_t;
	row_t rows [5] = '{
		'{12'h008, 32'hffff_ffff, 32'h0000_003f, 1'b0},
		'{12'h004, 32'hffff_ffff, 32'h0000_ff00, 1'b0},
		'{12'h004, 32'h0000_0700, 32'h0000_0700, 1'b0},
		'{12'h000, 32'h0000_00ff, 32'h0000_7700, 1'b0},
		'{12'h01c, 32'h0000_0001, 32'h0000_0000, 1'b1}
	};
	// ==========================================================
	// Design
	osc_ctrl osc_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg), .stat(stat),
		.ctrl(ctrl), .irq(irq)
	);
	always #25 pclk = ~pclk;
	// ==========================================================
	// Tasks
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			chk(32'h0, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	task automatic unl(input logic hi);
		if (hi) begin
			apb(1'b1, 12'h00c, 32'h7800);
			apb(1'b1, 12'h00c, 32'h9a00);
		end else begin
			apb(1'b1, 12'h010, 32'h0046);
			apb(1'b1, 12'h010, 32'h0057);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge pclk) stat.new_clk_tick <= ~stat.new_clk_tick;
	endtask
	// ==========================================================
	// Timeout
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc(12'h000, 32'h0000_7700);
		rdc(12'h004, 32'h0000_0100);
		rdc(12'h008, 32'h0000_0000);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk(er, rows[i].e);
			apb(1'b0, rows[i].a, 32'h0);
			if (!rows[i].e)
				chk(rd, rows[i].x);
		end
		@(posedge pclk);
		chk(ctrl.fast_rc_trim, 6'h3f);
		chk(ctrl.fast_rc_postscale, 3'h7);
		chk(ctrl.cpu_slow_ratio, 3'h0);
		apb(1'b1, 12'h004, 32'h0000_8800);
		@(posedge pclk);
		chk(ctrl.cpu_slow_on, 1'b1);
		stat.interrupt <= 1'b1;
		repeat (5) @(posedge pclk);
		rdc(12'h004, 32'h0000_8000);
		stat.interrupt <= 1'b0;
		unl(1'b1);
		apb(1'b1, 12'h000, 32'h0000_0000);
		rdc(12'h000, 32'h0000_7000);
		apb(1'b1, 12'h018, 32'h0000_0007);
		stat.pll_locked <= 1'b1;
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_0003);
		tick(20);
		chk(ctrl.active_src, SRC_FRC_DIV);
		chk(ctrl.sec_osc_on, 1'b1);
		@(posedge pclk) stat.src_ready <= 1'b1;
		for (n = 0; n < 80 && ctrl.active_src !== SRC_FRC; n++)
			tick(1);
		chk(ctrl.active_src, SRC_FRC);
		rdc(12'h000, 32'h0000_0002);
		chk(irq, 1'b1);
		rdc(12'h014, 32'h0000_0001);
		apb(1'b1, 12'h014, 32'h0000_0001);
		@(posedge pclk);
		chk(irq, 1'b0);
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_0003);
		tick(5);
		rdc(12'h000, 32'h0000_0002);
		rdc(12'h014, 32'h0000_0002);
		apb(1'b1, 12'h014, 32'h0000_0002);
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_0042);
		rdc(12'h000, 32'h0000_0042);
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_0002);
		rdc(12'h000, 32'h0000_0042);
		stat.clock_fail <= 1'b1;
		tick(5);
		rdc(12'h000, 32'h0000_004a);
		rdc(12'h014, 32'h0000_0004);
		@(posedge pclk) stat.clock_fail <= 1'b0;
		tick(3);
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_0042);
		rdc(12'h000, 32'h0000_0042);
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_00c2);
		unl(1'b1);
		apb(1'b1, 12'h000, 32'h0000_0400);
		unl(1'b0);
		apb(1'b1, 12'h000, 32'h0000_0043);
		tick(40);
		chk(ctrl.active_src, SRC_FRC);
		chk(ctrl.switching, 1'b0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd[7], 1'b1);
		// Mid-run reset returns to configured source
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc(12'h000, 32'h0000_7700);
		@(posedge pclk);
		chk(ctrl.active_src, SRC_FRC_DIV);
		chk(ctrl.sec_osc_on, 1'b0);
		tally_and_finish;
	end
endmodule
